// ---- logic/periph_irq_enable.sv ----
`timescale 1ns/1ps
// Behaviour
// - bit 7 set lets the timer1 gate event interrupt; clear blocks it.
// - bit 5 set lets the serial receive interrupt through; clear blocks it.
// - bit 4 set lets the serial transmit interrupt through; clear blocks it.
// - bit 3 set lets the sync serial port interrupt through; clear blocks it.
// - bit 2 has no storage: reads zero, writes ignored.
// - bit 1 set lets the timer2 period match interrupt through.
// - bit 0 set lets the timer1 overflow interrupt through.
module periph_irq_enable
  import periph_irq_pkg::*;
(
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  // ahb-lite slave
  input  wire periph_irq_pkg::ahb_req_t busReq,
  input  wire logic [31:0]              hwdata,
  output periph_irq_pkg::ahb_rsp_t      busRsp,
  // peripheral flags, bit positions as the enable register
  input  wire logic [7:0]               periphFlags,
  // gated requests
  output logic [7:0]                    periphReq,
  output logic                          cpuIrq,
  output logic                          irq
);
  import periph_irq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  enable_q, enable_d;
  logic [1:0]  control_q, control_d;
  logic [1:0]  status_q, status_d;
  logic [1:0]  mask_q, mask_d;
  logic        wrPend_q;
  logic [11:0] wrAddr_q;
  logic [31:0] rdData_q;
  logic [7:0]  periphReq_q;
  logic        cpuIrq_q;
  logic        irq_q;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  wire        addrValid = busReq.hsel && busReq.hready && (busReq.htrans == HTRANS_NONSEQ);
  wire [11:0] addrOff   = busReq.haddr[11:0];
  wire        rdAccept  = addrValid && !busReq.hwrite;
  wire        wrAccept  = addrValid && busReq.hwrite;

  // data phase write strobes
  wire wrEnable  = wrPend_q && (wrAddr_q == ADDR_ENABLE_1);
  wire wrControl = wrPend_q && (wrAddr_q == ADDR_CONTROL);
  wire wrStatus  = wrPend_q && (wrAddr_q == ADDR_STATUS);
  wire wrMask    = wrPend_q && (wrAddr_q == ADDR_MASK);

  // ----------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------
  // one gate per source; bit 2 has no flop so it can never pass
  wire [7:0] gated = periphFlags & enable_q & ENABLE_IMPL_MASK;
  wire       anyPeriph = |gated;
  wire       cpuLevel  = anyPeriph && control_q[BIT_PERIPH_GLOBAL]
                         && control_q[BIT_GLOBAL];
  wire       evRise    = cpuLevel && !cpuIrq_q;
  wire       evFall    = !cpuLevel && cpuIrq_q;
  wire [1:0] events    = {evFall, evRise};

  // next values: write-one-to-clear, a new event wins over the clear
  assign enable_d  = wrEnable ? (hwdata[7:0] & ENABLE_IMPL_MASK) : enable_q;
  assign control_d = wrControl ? hwdata[1:0] : control_q;
  assign status_d  = (status_q & ~(wrStatus ? hwdata[1:0] : 2'h0)) | events;
  assign mask_d    = wrMask ? hwdata[1:0] : mask_q;

  // read mux, unmapped addresses read zero
  wire [31:0] rdMux =
      (addrOff == ADDR_ENABLE_1) ? {24'h000000, enable_q & ENABLE_IMPL_MASK} :
      (addrOff == ADDR_CONTROL)  ? {30'h00000000, control_q} :
      (addrOff == ADDR_STATUS)   ? {30'h00000000, status_q} :
      (addrOff == ADDR_MASK)     ? {30'h00000000, mask_q} :
      (addrOff == ADDR_PENDING)  ? {24'h000000, gated} :
                                   32'h00000000;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // register file, all cleared by reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_q  <= ENABLE_RESET;
      control_q <= CONTROL_RESET;
      status_q  <= STATUS_RESET;
      mask_q    <= MASK_RESET;
    end else begin
      enable_q  <= enable_d;
      control_q <= control_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
    end
  end

  // bus phase tracking; zero wait states, so hreadyout stays high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
      rdData_q <= 32'h00000000;
    end else begin
      wrPend_q <= wrAccept;
      wrAddr_q <= addrOff;
      rdData_q <= rdAccept ? rdMux : 32'h00000000;
    end
  end

  // registered outputs; the request lags the flags by one cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      periphReq_q <= 8'h00;
      cpuIrq_q    <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      periphReq_q <= gated;
      cpuIrq_q    <= cpuLevel;
      irq_q       <= |(status_d & mask_d);
    end
  end

  assign busRsp.hrdata    = rdData_q;
  assign busRsp.hreadyout = 1'b1;
  assign busRsp.hresp     = 1'b0;
  assign periphReq        = periphReq_q;
  assign cpuIrq           = cpuIrq_q;
  assign irq              = irq_q;

endmodule

// ---- common/periph_irq_pkg.sv ----
package periph_irq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_ENABLE_1   = 12'h000; // peripheral_interrupt_enable_1
  localparam logic [11:0] ADDR_CONTROL    = 12'h004; // global enables
  localparam logic [11:0] ADDR_STATUS     = 12'h008; // sticky events, write one to clear
  localparam logic [11:0] ADDR_MASK       = 12'h00C; // event mask
  localparam logic [11:0] ADDR_PENDING    = 12'h010; // live gated request view

  // ----------------------------------------------------------------
  // enable register fields
  // ----------------------------------------------------------------
  localparam int BIT_TIMER1_GATE   = 7;
  localparam int BIT_ADC_DONE      = 6;
  localparam int BIT_SERIAL_RX     = 5;
  localparam int BIT_SERIAL_TX     = 4;
  localparam int BIT_SYNC_SERIAL   = 3;
  localparam int BIT_UNUSED        = 2;
  localparam int BIT_TIMER2_MATCH  = 1;
  localparam int BIT_TIMER1_OVF    = 0;
  localparam logic [7:0] ENABLE_IMPL_MASK = 8'hFB;
  localparam logic [7:0] ENABLE_RESET     = 8'h00;

  // control register fields
  localparam int BIT_PERIPH_GLOBAL = 0;
  localparam int BIT_GLOBAL        = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // status/mask fields
  localparam int BIT_EV_RISE = 0; // processor request rose
  localparam int BIT_EV_FALL = 1; // processor request fell
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET   = 2'h0;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

endpackage

// ---- dv/periph_irq_monitor.sv ----
`timescale 1ns/1ps
module periph_irq_monitor
  import periph_irq_pkg::*;
(
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     sys_rst,
  // bus and flags
  input wire periph_irq_pkg::ahb_req_t busReq,
  input wire logic [31:0]              hwdata,
  input wire periph_irq_pkg::ahb_rsp_t busRsp,
  input wire logic [7:0]               periphFlags,
  // gated requests
  input wire logic [7:0]               periphReq,
  input wire logic                     cpuIrq,
  input wire logic                     irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // read of the enable register taken, then its data phase
  wire rdTaken = busReq.hsel && busReq.hready && busReq.htrans == HTRANS_NONSEQ && !busReq.hwrite;
  sequence s_enable_read;
    rdTaken && busReq.haddr[11:0] == ADDR_ENABLE_1 ##1 1'b1;
  endsequence
  a_req_subset: assert property ((periphReq & ~$past(periphFlags)) == 8'h00)
    else $error("request without its flag");
  a_bit2_req: assert property (periphReq[2] == 1'b0)
    else $error("unused position passed a request");
  a_bit2_read: assert property (s_enable_read |-> busRsp.hrdata[2] == 1'b0)
    else $error("unused position read as one");
  a_read_width: assert property (s_enable_read |-> busRsp.hrdata[31:8] == 24'h0)
    else $error("enable read wider than eight bits");
  a_cpu_cause: assert property (cpuIrq |-> ($past(periphFlags) & ENABLE_IMPL_MASK) != 8'h00)
    else $error("processor request without a flag");
  a_flags_quiet: assert property (periphFlags == 8'h00 |=> periphReq == 8'h00 && !cpuIrq)
    else $error("request stayed after flags dropped");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> periphReq == 8'h00 && !cpuIrq && !irq)
    else $error("outputs not cleared by reset");
  a_bus_okay: assert property (busRsp.hreadyout && !busRsp.hresp)
    else $error("bus answer not ready and okay");
endmodule
bind periph_irq_enable periph_irq_monitor MON (.core_clk, .sys_rst, .busReq, .hwdata, .busRsp,
  .periphFlags, .periphReq, .cpuIrq, .irq);

// ---- dv/periph_flag_model.sv ----
`timescale 1ns/1ps
module periph_flag_model (
  // clock and flag control
  input  wire logic       core_clk,
  input  wire logic [7:0] setFlags,
  input  wire logic [7:0] clrFlags,
  // flag levels, unused position driven too so its blocking is seen
  output logic      [7:0] periphFlags
);
  // sticky like real peripheral flags, cleared only on request
  always_ff @(posedge core_clk) begin
    periphFlags <= (periphFlags | setFlags) & ~clrFlags;
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import periph_irq_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, cpuIrq, irq;
  logic [1:0] tr = HTRANS_IDLE;
  logic [11:0] ad = 12'h000;
  logic [31:0] hwdata = 32'h0, d;
  logic [7:0] setFlags = 8'h00, clrFlags = 8'hFF, periphFlags, periphReq;
  int mismatches = 0, checks = 0;
  ahb_req_t busReq;
  ahb_rsp_t busRsp;
  always #10 core_clk = ~core_clk;
  // one slave, so its ready is the bus ready
  assign busReq = '{tr, {20'h0, ad}, wr, HSIZE_WORD, 1'b1, busRsp.hreadyout};
  periph_flag_model FLAGS (.core_clk, .setFlags, .clrFlags, .periphFlags);
  periph_irq_enable DUT (.core_clk, .sys_rst, .busReq, .hwdata, .busRsp, .periphFlags,
    .periphReq, .cpuIrq, .irq);
  // single word transfer, read data lands in d
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    tr <= HTRANS_NONSEQ;
    ad <= a;
    wr <= w;
    do @(posedge core_clk); while (busRsp.hreadyout !== 1'b1);
    tr <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge core_clk); while (busRsp.hreadyout !== 1'b1);
    d = busRsp.hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // tests need well under a thousand cycles
  initial begin
    #100us;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    clrFlags <= 8'h00;
    setFlags <= 8'hFF;
    bus(1'b0, ADDR_ENABLE_1, 32'h0);
    setFlags <= 8'h00;
    chk(d, 32'h0);
    bus(1'b1, ADDR_ENABLE_1, 32'hFFFF_FFFF);
    bus(1'b0, ADDR_ENABLE_1, 32'h0);
    chk(d, {24'h0, ENABLE_IMPL_MASK});
    // one enable at a time, all flags raised
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ADDR_ENABLE_1, 32'h1 << i);
      bus(1'b0, ADDR_PENDING, 32'h0);
      chk({24'h0, periphReq}, (32'h1 << i) & 32'hFB);
      chk(d, (32'h1 << i) & 32'hFB);
    end
    bus(1'b1, ADDR_ENABLE_1, 32'hFF);
    bus(1'b1, ADDR_MASK, 32'h1);
    bus(1'b1, ADDR_CONTROL, 32'h1);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk({d[30:0], cpuIrq}, 32'h2);
    bus(1'b1, ADDR_CONTROL, 32'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk({d[29:0], cpuIrq, irq}, 32'h7);
    bus(1'b1, ADDR_STATUS, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk({d[30:0], irq}, 32'h0);
    // flags drop: fall event is masked, so irq stays low
    clrFlags <= 8'hFF;
    // the fall event lands one edge after the flags drop, so let it settle before reading
    @(posedge core_clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk({d[29:0], cpuIrq, irq}, 32'h8);
    bus(1'b0, 12'h020, 32'h0);
    chk(d, 32'h0);
    tally_and_finish;
  end
endmodule
